/* verilog/gpcl_pkg.sv */
// Shared constants, types and reset helpers for the pad enable / commit lock block
package gpcl_pkg;

  // Register byte offsets on the slave bus
  localparam logic [11:0] OFS_ENABLE = 12'h51C;
  localparam logic [11:0] OFS_LOCK   = 12'h520;
  localparam logic [11:0] OFS_COMMIT = 12'h524;
  localparam logic [11:0] OFS_AFSEL  = 12'h528;
  localparam logic [11:0] OFS_ID4    = 12'hFD0;
  localparam logic [11:0] OFS_ID5    = 12'hFD4;
  localparam logic [11:0] OFS_ID6    = 12'hFD8;
  localparam logic [11:0] OFS_ID7    = 12'hFDC;

  // Lock key and lock status read values
  localparam logic [31:0] UNLOCK_KEY    = 32'h1ACCE551;
  localparam logic [31:0] STAT_LOCKED   = 32'h00000001;
  localparam logic [31:0] STAT_UNLOCKED = 32'h00000000;

  // Per-kind reset values and writable commit bits
  localparam logic [7:0] ENA_RST_ORD = 8'h00;
  localparam logic [7:0] ENA_RST_B   = 8'h80;
  localparam logic [7:0] ENA_RST_C   = 8'h0F;
  localparam logic [7:0] CMT_RST_ORD = 8'hFF;
  localparam logic [7:0] CMT_RST_B   = 8'h7F;
  localparam logic [7:0] CMT_RST_C   = 8'hF0;
  localparam logic [7:0] CMT_WR_ORD  = 8'h00;
  localparam logic [7:0] CMT_WR_B    = 8'h80;
  localparam logic [7:0] CMT_WR_C    = 8'h0F;

  // Which flavour of port an instance is
  typedef enum logic [1:0] {GPCL_ORDINARY, GPCL_PORT_B, GPCL_PORT_C} gpcl_kind_type;

  // Slave bus request bundle, Avalon-MM field names
  typedef struct packed {
    logic        read;
    logic        write;
    logic [11:0] address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } gpcl_avreq_type;

  // Digital enable (and alt select) reset value
  function automatic logic [7:0] gpclEnaReset(gpcl_kind_type k);
    case (k)
      GPCL_PORT_B: return ENA_RST_B;
      GPCL_PORT_C: return ENA_RST_C;
      default:     return ENA_RST_ORD;
    endcase
  endfunction

  // Commit mask reset value
  function automatic logic [7:0] gpclCmtReset(gpcl_kind_type k);
    case (k)
      GPCL_PORT_B: return CMT_RST_B;
      GPCL_PORT_C: return CMT_RST_C;
      default:     return CMT_RST_ORD;
    endcase
  endfunction

  // Commit mask bits that software may change
  function automatic logic [7:0] gpclCmtWritable(gpcl_kind_type k);
    case (k)
      GPCL_PORT_B: return CMT_WR_B;
      GPCL_PORT_C: return CMT_WR_C;
      default:     return CMT_WR_ORD;
    endcase
  endfunction

endpackage

/* verilog/gpcl_pad_cell.sv */
// One pad: input synchroniser, receiver gate and driver gate
`timescale 1ns/1ps
module gpcl_pad_cell (
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic digEnable,
  input  wire logic altSel,
  input  wire logic gpioOut,
  input  wire logic gpioOe,
  input  wire logic altOut,
  input  wire logic altOe,
  input  wire logic padIn,
  output logic      padOut,
  output logic      padOe,
  output logic      rxData
);

  logic sync1_r;     // First stage, read only by second
  logic sync2_r;     // Second stage
  logic sync3_r;     // Third stage
  logic padLevel_r;  // Filtered pin level

  // Three-stage capture of the asynchronous pin
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end else begin
      sync1_r <= padIn;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // Level moves only once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      padLevel_r <= 1'b0;
    end else if (sync2_r == sync3_r) begin
      padLevel_r <= sync3_r;
    end
  end

  // Receiver gate: disabled pad feeds a constant zero
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rxData <= 1'b0;
    end else begin
      rxData <= digEnable & padLevel_r;
    end
  end

  // Driver gate: disabled pad stays undriven, alt path wins when selected
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      padOe  <= 1'b0;
      padOut <= 1'b0;
    end else begin
      padOe  <= digEnable & (altSel ? altOe : gpioOe);
      padOut <= digEnable & (altSel ? altOut : gpioOut);
    end
  end

endmodule // gpcl_pad_cell

/* verilog/gpcl_port.sv */
// Port control: pad digital enable, commit lock, commit mask, alt select, ident
//
// Operation
// - Disabled pad neither drives nor feeds receiver.
// - Any digital use needs its enable bit.
// - Enable resets zero; debug ports keep debug pins.
// - Full key write unlocks the commit mask.
// - Other key or commit write relocks.
// - Lock reads status: one locked, zero unlocked.
// - Commit mask writes ignored while locked.
// - Mask zero discards alt select bit write.
// - Mask one lets alt select bit update.
// - Unprotected mask bits read-only, fixed at one.
// - Only B7 and C3..C0 mask bits writable.
// - Mask resets FF, B 7F, C F0.
// - Four read-only ident bytes form one word.
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
module gpcl_port
  import gpcl_pkg::*;
#(
  parameter gpcl_kind_type PORT_KIND  = GPCL_ORDINARY,
  // Arbitrary identification word, low byte first
  parameter logic [31:0]   IDENT_WORD = 32'h5A3C96E1
) (
  input  wire logic            clk_sys,
  input  wire gpcl_avreq_type  avsReq,
  input  wire logic            srst,
  input  wire logic [7:0]      padIn,
  input  wire logic [7:0]      gpioOut,
  input  wire logic [7:0]      gpioOe,
  input  wire logic [7:0]      altOut,
  input  wire logic [7:0]      altOe,
  output logic                 waitrequest,
  output logic [31:0]          readdata,
  output logic [7:0]           padOut,
  output logic [7:0]           padOe,
  output logic [7:0]           rxData,
  output logic [7:0]           digitalEnable,
  output logic [7:0]           altSelect
);

  ////////////////////////////////////////////////////////////////////////////
  // Constants fixed by the port kind

  localparam logic [7:0] ENA_RST = gpclEnaReset(PORT_KIND);
  localparam logic [7:0] CMT_RST = gpclCmtReset(PORT_KIND);
  localparam logic [7:0] CMT_WR  = gpclCmtWritable(PORT_KIND);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  // Bus handshake states
  typedef enum logic {BUS_IDLE, BUS_ANSWER} gpcl_bus_type;

  gpcl_bus_type busState_r;       // Handshake state
  logic         waitReq_r;        // Registered waitrequest
  logic [31:0]  readData_r;       // Registered read answer
  logic [31:0]  readData_nxt;     // Read mux output
  logic [7:0]   enaBits_r;        // Digital enable bits
  logic [7:0]   cmtBits_r;        // Stored commit mask
  logic [7:0]   cmtRead;          // Commit mask as software sees it
  logic [7:0]   afselBits_r;      // Alt function select bits
  logic         lockState_r;      // One while commit mask locked
  logic         wrAcc;            // Write taken this edge
  logic         rdAcc;            // Read answered this edge
  logic         newReq;           // Fresh request seen while idle
  logic         keyMatch;         // Full key on all lanes
  logic         lane0;            // Low byte lane enabled

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode helpers

  // Request seen while idle is answered on the next cycle
  assign newReq   = (busState_r == BUS_IDLE) && (avsReq.read || avsReq.write);
  // Write and read complete at the edge where waitrequest is low
  assign wrAcc    = (busState_r == BUS_ANSWER) && avsReq.write;
  assign rdAcc    = (busState_r == BUS_ANSWER) && avsReq.read;
  assign lane0    = avsReq.byteenable[0];
  // A partial write can never carry the key, so it locks
  assign keyMatch = (avsReq.writedata == UNLOCK_KEY) && (avsReq.byteenable == 4'hF);

  // Non-writable mask bits are hardwired to one
  assign cmtRead = cmtBits_r | ~CMT_WR;

  ////////////////////////////////////////////////////////////////////////////
  // Handshake: one wait cycle, then one answer cycle

  // Fixed latency keeps the master's timing simple and predictable
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      busState_r <= BUS_IDLE;
      waitReq_r  <= 1'b1;
    end else begin
      case (busState_r)
        BUS_IDLE: begin
          if (newReq) begin
            busState_r <= BUS_ANSWER;
            waitReq_r  <= 1'b0;
          end
        end
        BUS_ANSWER: begin
          // Master releases after this edge
          busState_r <= BUS_IDLE;
          waitReq_r  <= 1'b1;
        end
        default: begin
          busState_r <= BUS_IDLE;
          waitReq_r  <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer

  // Reserved bits and unmapped offsets read as zero
  always_comb begin
    readData_nxt = 32'h00000000;
    case (avsReq.address)
      OFS_ENABLE: readData_nxt = {24'h000000, enaBits_r};
      // Status, not the last value written
      OFS_LOCK:   readData_nxt = lockState_r ? STAT_LOCKED : STAT_UNLOCKED;
      OFS_COMMIT: readData_nxt = {24'h000000, cmtRead};
      OFS_AFSEL: readData_nxt = {24'h000000, afselBits_r};
      // Identification bytes, read-only
      OFS_ID4:   readData_nxt = {24'h000000, IDENT_WORD[7:0]};
      OFS_ID5:   readData_nxt = {24'h000000, IDENT_WORD[15:8]};
      OFS_ID6:   readData_nxt = {24'h000000, IDENT_WORD[23:16]};
      OFS_ID7:   readData_nxt = {24'h000000, IDENT_WORD[31:24]};
      default:   readData_nxt = 32'h00000000;
    endcase
  end

  // Answer captured when the request is first seen
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      readData_r <= 32'h00000000;
    end else if (newReq && avsReq.read) begin
      readData_r <= readData_nxt;
    end else if (busState_r == BUS_ANSWER) begin
      // Clear after the answer so stale data never lingers
      readData_r <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Digital enable register

  // Reset leaves only the debug pins enabled
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      enaBits_r <= ENA_RST;
    end else if (wrAcc && lane0 && avsReq.address == OFS_ENABLE) begin
      enaBits_r <= avsReq.writedata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lock state, private to this port

  // Any commit write relocks, even one that was ignored
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      lockState_r <= 1'b1;
    end else if (wrAcc && avsReq.address == OFS_LOCK) begin
      lockState_r <= !keyMatch;
    end else if (wrAcc && avsReq.address == OFS_COMMIT) begin
      lockState_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Commit mask

  // Only protected bits move; others hold their reset ones
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cmtBits_r <= CMT_RST;
    end else if (wrAcc && lane0 && avsReq.address == OFS_COMMIT && !lockState_r) begin
      cmtBits_r <= (cmtBits_r & ~CMT_WR) | (avsReq.writedata[7:0] & CMT_WR);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alternate function select, filtered by the commit mask

  // Masked-off bits keep their old value so debug pins stay put
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      afselBits_r <= ENA_RST;
    end else if (wrAcc && lane0 && avsReq.address == OFS_AFSEL) begin
      afselBits_r <= (afselBits_r & ~cmtRead)
                   | (avsReq.writedata[7:0] & cmtRead);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pads

  // Each pad gated by its own enable bit
  for (genvar i = 0; i < 8; i++) begin : g_pad
    gpcl_pad_cell u_pad (
      .clk_sys   (clk_sys),
      .srst      (srst),
      .digEnable (enaBits_r[i]),
      .altSel    (afselBits_r[i]),
      .gpioOut   (gpioOut[i]),
      .gpioOe    (gpioOe[i]),
      .altOut    (altOut[i]),
      .altOe     (altOe[i]),
      .padIn     (padIn[i]),
      .padOut    (padOut[i]),
      .padOe     (padOe[i]),
      .rxData    (rxData[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign waitrequest   = waitReq_r;
  assign readdata      = readData_r;
  assign digitalEnable = enaBits_r;
  assign altSelect     = afselBits_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  // Write completion to a given register
  sequence s_wrLock;
    wrAcc && avsReq.address == OFS_LOCK;
  endsequence

  sequence s_wrCmt;
    wrAcc && avsReq.address == OFS_COMMIT;
  endsequence

  // Pad output and receiver flops follow the enable one cycle late
  property p_padIsolate;
    ((padOe | rxData | padOut) & ~$past(enaBits_r)) == 8'h00;
  endproperty
  a_padIsolate: assert property (p_padIsolate)
    else $error("Disabled pad drove or received");

  // Enabled, selected gpio drive reaches the pin in two cycles
  property p_padDrive;
    (enaBits_r[0] && !afselBits_r[0] && gpioOe[0]) ##1 1'b1
      |=> padOe[0] == $past(enaBits_r[0], 1);
  endproperty
  a_padDrive: assert property (p_padDrive)
    else $error("Enabled pad did not drive");

  // Reset values appear right after reset release
  property p_resetVals;
    $fell(srst) |-> enaBits_r == ENA_RST && cmtRead == CMT_RST && lockState_r;
  endproperty
  a_resetVals: assert property (p_resetVals)
    else $error("Wrong value after reset");

  // Full key opens the lock; waitrequest is back high on the next cycle
  property p_unlock;
    s_wrLock ##0 keyMatch |=> !lockState_r && waitrequest;
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("Key write did not unlock");

  // Any other lock value, or a mask write, relocks
  property p_relock;
    (s_wrLock ##0 !keyMatch) or s_wrCmt |=> lockState_r;
  endproperty
  a_relock: assert property (p_relock)
    else $error("Lock not reapplied");

  // Lock read returns status only
  property p_lockRead;
    rdAcc && avsReq.address == OFS_LOCK |-> readdata == {31'h0, lockState_r};
  endproperty
  a_lockRead: assert property (p_lockRead)
    else $error("Lock read not status");

  // Locked mask write leaves the mask unchanged
  property p_cmtLocked;
    s_wrCmt ##0 lockState_r |=> $stable(cmtBits_r);
  endproperty
  a_cmtLocked: assert property (p_cmtLocked)
    else $error("Locked mask changed");

  // Select bits with mask zero keep their value
  property p_afHold;
    wrAcc && avsReq.address == OFS_AFSEL
      |=> (afselBits_r & ~$past(cmtRead)) == ($past(afselBits_r) & ~$past(cmtRead));
  endproperty
  a_afHold: assert property (p_afHold)
    else $error("Uncommitted select bit changed");

  // Select bits with mask one take the written value
  property p_afTake;
    wrAcc && lane0 && avsReq.address == OFS_AFSEL
      |=> (afselBits_r & $past(cmtRead)) == ($past(avsReq.writedata[7:0]) & $past(cmtRead));
  endproperty
  a_afTake: assert property (p_afTake)
    else $error("Committed select bit not written");

  // Unprotected mask bits read back as one on the bus
  property p_cmtFixed;
    rdAcc && avsReq.address == OFS_COMMIT |-> (readdata[7:0] & ~CMT_WR) == ~CMT_WR;
  endproperty
  a_cmtFixed: assert property (p_cmtFixed)
    else $error("Fixed mask bit not one");

  // Ident low byte answers with the word's bits 7:0
  property p_ident;
    rdAcc && avsReq.address == OFS_ID4 |-> readdata == {24'h000000, IDENT_WORD[7:0]};
  endproperty
  a_ident: assert property (p_ident)
    else $error("Ident byte wrong");

  // Request answered exactly one cycle after it appears
  property p_latency;
    newReq |=> !waitrequest ##1 waitrequest;
  endproperty
  a_latency: assert property (p_latency)
    else $error("Bus latency wrong");

  // Enable write lands at the completing edge, full byte
  property p_enaWrite;
    wrAcc && lane0 && avsReq.address == OFS_ENABLE
      |=> enaBits_r == $past(avsReq.writedata[7:0]);
  endproperty
  a_enaWrite: assert property (p_enaWrite)
    else $error("Enable write did not land");

  // Read data is zero outside the answer cycle
  property p_readIdle;
    busState_r == BUS_IDLE |-> readdata == 32'h00000000;
  endproperty
  a_readIdle: assert property (p_readIdle)
    else $error("Read data outside answer cycle");

endmodule // gpcl_port

/* bench/gpio_pad_enable_commit_lock_tb.sv */
// Self-checking bench for the pad enable / commit lock port logic
`timescale 1ns/1ps
module gpio_pad_enable_commit_lock_tb;
  import gpcl_pkg::*;

  // Arbitrary identification word for the bench instances
  localparam logic [31:0] ID_WORD = 32'hC0FFEE42;

  ////////////////////////////////////////////////////////////////////////////
  // Signals; index 0 is the port C instance, index 1 the port B instance
  logic           clk_sys;      // System clock
  logic           srst;         // Sync reset
  gpcl_avreq_type req [2];      // Bus requests
  logic           waitReq [2];  // Bus answer strobes
  logic [31:0]    rdata [2];    // Read data
  logic [7:0]     padIn;        // Pin levels
  logic [7:0]     gpioOut;      // Core drive data
  logic [7:0]     gpioOe;       // Core drive enable
  logic [7:0]     altOut;       // Alt drive data
  logic [7:0]     altOe;        // Alt drive enable
  logic [7:0]     pOut [2];     // Pin drive levels
  logic [7:0]     pOe [2];      // Pin enables
  logic [7:0]     rx [2];       // Receiver levels
  logic [7:0]     digital_enable_bits [2];      // Enable bits
  logic [7:0]     afs [2];      // Alt select bits
  int             err_total;    // Mismatches
  int             check_count;  // Comparisons
  int             cycles = 0;   // Hang guard
  logic [31:0]    q;            // Scratch read value

  ////////////////////////////////////////////////////////////////////////////
  // Devices under test; two kinds so per-instance state can be seen
  gpcl_port #(.PORT_KIND(GPCL_PORT_C), .IDENT_WORD(ID_WORD)) u_dut (
    .clk_sys(clk_sys), .avsReq(req[0]), .srst(srst), .padIn(padIn), .gpioOut(gpioOut),
    .gpioOe(gpioOe), .altOut(altOut), .altOe(altOe), .waitrequest(waitReq[0]),
    .readdata(rdata[0]), .padOut(pOut[0]), .padOe(pOe[0]), .rxData(rx[0]),
    .digitalEnable(digital_enable_bits[0]), .altSelect(afs[0]));
  gpcl_port #(.PORT_KIND(GPCL_PORT_B), .IDENT_WORD(ID_WORD)) u_dut_b (
    .clk_sys(clk_sys), .avsReq(req[1]), .srst(srst), .padIn(padIn), .gpioOut(gpioOut),
    .gpioOe(gpioOe), .altOut(altOut), .altOe(altOe), .waitrequest(waitReq[1]),
    .readdata(rdata[1]), .padOut(pOut[1]), .padOe(pOe[1]), .rxData(rx[1]),
    .digitalEnable(digital_enable_bits[1]), .altSelect(afs[1]));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, 8 ns period
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Hang guard; whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total = err_total + 1;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare one value, report at once
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One bus cycle; an edge always passes before a request rises again
  task automatic bus(input int p, input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_sys);
    req[p].read       <= ~w;
    req[p].write      <= w;
    req[p].address    <= a;
    req[p].writedata  <= d;
    req[p].byteenable <= 4'hF;
    // Held until the edge that sees waitrequest low
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitReq[p] !== 1'b0 && n < 50);
    if (n >= 50) err_total = err_total + 1;
    r = rdata[p];
    req[p].read  <= 1'b0;
    req[p].write <= 1'b0;
  endtask

  // Write helper; read data of a write is meaningless
  task automatic wr(input int p, input logic [11:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(p, 1'b1, a, d, dummy);
  endtask

  // Read helper, result left in q
  task automatic rd(input int p, input logic [11:0] a);
    bus(p, 1'b0, a, 32'h0, q);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Reset values of both kinds, over the bus and at the outputs
  task automatic t_reset;
    rd(0, OFS_ENABLE);
    chk(q, 32'h0000000F);
    rd(1, OFS_ENABLE);
    chk(q, 32'h00000080);
    chk({16'h0, digital_enable_bits[0], digital_enable_bits[1]}, 32'h00000F80);
    rd(0, OFS_LOCK);
    chk(q, 32'h00000001);
    rd(0, OFS_COMMIT);
    chk(q, 32'h000000F0);
    rd(1, OFS_COMMIT);
    chk(q, 32'h0000007F);
    $display("t_reset done");
  endtask

  // Lock key handling and commit mask write filtering
  task automatic t_lock;
    wr(0, OFS_COMMIT, 32'h000000FF);
    rd(0, OFS_COMMIT);
    chk(q, 32'h000000F0);
    wr(0, OFS_LOCK, 32'h1ACCE551);
    rd(0, OFS_LOCK);
    chk(q, 32'h00000000);
    rd(1, OFS_LOCK);
    chk(q, 32'h00000001);
    wr(0, OFS_COMMIT, 32'h00000000);
    rd(0, OFS_COMMIT);
    chk(q, 32'h000000F0);
    rd(0, OFS_LOCK);
    chk(q, 32'h00000001);
    // Near-miss key must relock
    wr(0, OFS_LOCK, 32'h1ACCE551);
    wr(0, OFS_LOCK, 32'h1ACCE550);
    rd(0, OFS_LOCK);
    chk(q, 32'h00000001);
    wr(0, OFS_LOCK, 32'h1ACCE551);
    wr(0, OFS_COMMIT, 32'h00000005);
    rd(0, OFS_COMMIT);
    chk(q, 32'h000000F5);
    // Port B mask bit 7 writable both ways, the rest stuck at one
    wr(1, OFS_LOCK, 32'h1ACCE551);
    wr(1, OFS_COMMIT, 32'h00000080);
    rd(1, OFS_COMMIT);
    chk(q, 32'h000000FF);
    wr(1, OFS_LOCK, 32'h1ACCE551);
    wr(1, OFS_COMMIT, 32'h00000000);
    rd(1, OFS_COMMIT);
    chk(q, 32'h0000007F);
    $display("t_lock done");
  endtask

  // Alt select writes pass only where the mask is one
  task automatic t_commit;
    wr(0, OFS_AFSEL, 32'h00000000);
    rd(0, OFS_AFSEL);
    chk(q, 32'h0000000A);
    chk({24'h0, afs[0]}, 32'h0000000A);
    wr(0, OFS_AFSEL, 32'h000000FF);
    rd(0, OFS_AFSEL);
    chk(q, 32'h000000FF);
    wr(1, OFS_AFSEL, 32'h00000000);
    rd(1, OFS_AFSEL);
    chk(q, 32'h00000080);
    $display("t_commit done");
  endtask

  // Pads isolated when disabled, live on the chosen path when enabled
  task automatic t_pads;
    wr(1, OFS_ENABLE, 32'h00000000);
    repeat (8) @(posedge clk_sys);
    chk({8'h0, pOut[1], pOe[1], rx[1]}, 32'h00000000);
    wr(1, OFS_ENABLE, 32'h0000008F);
    repeat (8) @(posedge clk_sys);
    chk({24'h0, digital_enable_bits[1]}, 32'h0000008F);
    chk({8'h0, pOut[1], pOe[1], rx[1]}, 32'h008A8F83);
    // Port C debug pins now on the alt path, upper pins dark
    chk({8'h0, pOut[0], pOe[0], rx[0]}, 32'h00000F03);
    $display("t_pads done");
  endtask

  // Ident bytes, read-only places and an unmapped address
  task automatic t_ident;
    for (int i = 0; i < 4; i++) begin
      rd(0, OFS_ID4 + 12'(4 * i));
      chk(q, {24'h0, ID_WORD[8 * i +: 8]});
    end
    wr(0, OFS_ID4, 32'h000000AA);
    rd(0, OFS_ID4);
    chk(q, {24'h0, ID_WORD[7:0]});
    wr(0, 12'h100, 32'h000000AA);
    rd(0, 12'h100);
    chk(q, 32'h00000000);
    $display("t_ident done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Counts, verdict and end of run
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    err_total = 0;
    check_count = 0;
    srst = 1'b1;
    padIn = 8'hC3;
    gpioOut = 8'hAA;
    gpioOe = 8'hFF;
    altOut = 8'h80;
    altOe = 8'hFF;
    for (int p = 0; p < 2; p++) begin
      req[p] = '0;
    end
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset();
    t_lock();
    t_commit();
    t_pads();
    t_ident();
    final_report();
  end

endmodule // gpio_pad_enable_commit_lock_tb
